// ===== core/eof_energy_ctl.sv
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - peak period uses per-relay peak stop level
// - time-of-day relay trips at matching HH:MM
// - override touches only pump relays 50-56
// - override on manual input or flow condition
// - selector: 0 none, 1-16 discrete inputs
// - manual override unlatched, ends with peak
// - override status codes 0,1,2,3
// - source type or point zero disables detection
// - source type decode 1 to 6
// - points 1,2 transducers, 3 combined reading
// - discrete points 1-8 base, 9-16 card
// - ON level ignored for discrete sources
// - overflow needs ON above OFF
// - underflow needs OFF above ON
// - rate sources use signed rate thresholds
// - peak period pumping between peak levels
// - condition clears past OFF or input release
// - flow status 0 normal, 1 over, 2 under
// - energy mode 0 off, 1 avoid, 2 overridable
module eof_energy_ctl (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [7:0]                 wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   // measurements, same clock
   input  wire logic                       upd_i,
   input  wire logic [3*eof_pkg::LW-1:0]   level_i,
   input  wire logic [3*eof_pkg::LW-1:0]   rate_i,
   // time of day and high-cost period, same clock
   input  wire logic [4:0]                 hour_i,
   input  wire logic [5:0]                 minute_i,
   input  wire logic                       peak_i,
   // discrete float inputs, from pins
   input  wire logic [15:0]                disc_i,
   // relay decisions and status
   output logic [eof_pkg::NREL-1:0]        relay_o,
   output logic [1:0]                      flow_status_o,
   output logic [2*eof_pkg::NREL-1:0]      override_status_o
);
   localparam int N = eof_pkg::NREL;
   localparam int W = eof_pkg::LW;

   // ==========================================
   // helpers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic is_pump(input logic [7:0] f);
      is_pump = (f >= eof_pkg::FN_PUMP_LO) && (f <= eof_pkg::FN_PUMP_HI);
   endfunction

   // ==========================================
   // configuration registers
   logic [1:0]   energy_saving_mode;
   logic [4:0]   manual_override_input_select;
   logic [2:0]   flow_src_type;
   logic [4:0]   flow_src_point;
   logic [W-1:0] flow_on_level;
   logic [W-1:0] flow_off_level;
   logic [7:0]   relay_control_function [N];
   logic [W-1:0] on_level      [N];
   logic [W-1:0] off_level     [N];
   logic [W-1:0] peak_start_level [N];
   logic [W-1:0] peak_stop_level  [N];
   logic [4:0]   trip_hour     [N];
   logic [5:0]   trip_minute   [N];

   // ==========================================
   // bus decode
   logic         req;
   logic         wr;
   logic         rel_hit;
   logic [2:0]   rel_blk;
   logic [2:0]   fld;
   logic [1:0]   ri;
   logic [31:0]  next_dat;

   assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr      = req && wb_we_i;
   assign rel_blk = wb_adr_i[7:5];
   assign fld     = wb_adr_i[4:2];
   assign ri      = 2'(rel_blk - eof_pkg::REL_BASE);
   assign rel_hit = (rel_blk >= eof_pkg::REL_BASE) &&
                    (rel_blk < 3'(eof_pkg::REL_BASE + 3'(N)));

   // answer one cycle after the request, drop the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // global register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         energy_saving_mode           <= eof_pkg::ES_OFF;
         manual_override_input_select <= 5'h00;
         flow_src_type                <= eof_pkg::ST_OFF;
         flow_src_point               <= 5'h00;
         flow_on_level                <= 16'h0000;
         flow_off_level               <= 16'h0000;
      end else if (wr) begin
         case (wb_adr_i)
            eof_pkg::A_CTRL: begin
               if (wb_sel_i[0]) energy_saving_mode <= wb_dat_i[1:0];
               if (wb_sel_i[1]) manual_override_input_select <= wb_dat_i[12:8];
            end
            eof_pkg::A_FSRC: begin
               if (wb_sel_i[0]) flow_src_type  <= wb_dat_i[2:0];
               if (wb_sel_i[1]) flow_src_point <= wb_dat_i[12:8];
            end
            eof_pkg::A_FON:  flow_on_level  <= merge16(flow_on_level, wb_dat_i, wb_sel_i);
            eof_pkg::A_FOFF: flow_off_level <= merge16(flow_off_level, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // per-relay register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int r = 0; r < N; r++) begin
            relay_control_function[r] <= 8'h00;
            on_level[r]               <= 16'h0000;
            off_level[r]              <= 16'h0000;
            peak_start_level[r]       <= 16'h0000;
            peak_stop_level[r]        <= 16'h0000;
            trip_hour[r]              <= 5'h00;
            trip_minute[r]            <= 6'h00;
         end
      end else if (wr && rel_hit) begin
         case (fld)
            eof_pkg::F_FUNC: begin
               if (wb_sel_i[0]) relay_control_function[ri] <= wb_dat_i[7:0];
            end
            eof_pkg::F_ON:    on_level[ri]  <= merge16(on_level[ri], wb_dat_i, wb_sel_i);
            eof_pkg::F_OFF:   off_level[ri] <= merge16(off_level[ri], wb_dat_i, wb_sel_i);
            eof_pkg::F_PKON:
               peak_start_level[ri] <= merge16(peak_start_level[ri], wb_dat_i, wb_sel_i);
            eof_pkg::F_PKOFF:
               peak_stop_level[ri] <= merge16(peak_stop_level[ri], wb_dat_i, wb_sel_i);
            eof_pkg::F_TOD: begin
               if (wb_sel_i[0]) trip_minute[ri] <= wb_dat_i[5:0];
               if (wb_sel_i[1]) trip_hour[ri]   <= wb_dat_i[12:8];
            end
            default: ;
         endcase
      end
   end

   // read mux; unmapped words read zero
   always_comb begin
      next_dat = 32'h0000_0000;
      case (wb_adr_i)
         eof_pkg::A_CTRL: next_dat = {19'h0, manual_override_input_select, 6'h0,
                                      energy_saving_mode};
         eof_pkg::A_FSRC: next_dat = {19'h0, flow_src_point, 5'h0, flow_src_type};
         eof_pkg::A_FON:  next_dat = {16'h0, flow_on_level};
         eof_pkg::A_FOFF: next_dat = {16'h0, flow_off_level};
         eof_pkg::A_STAT: next_dat = {12'h0, 4'(relay_o), 6'h0, flow_status_o,
                                      8'(override_status_o)};
         default: begin
            if (rel_hit) begin
               case (fld)
                  eof_pkg::F_FUNC:  next_dat = {24'h0, relay_control_function[ri]};
                  eof_pkg::F_ON:    next_dat = {16'h0, on_level[ri]};
                  eof_pkg::F_OFF:   next_dat = {16'h0, off_level[ri]};
                  eof_pkg::F_PKON:  next_dat = {16'h0, peak_start_level[ri]};
                  eof_pkg::F_PKOFF: next_dat = {16'h0, peak_stop_level[ri]};
                  eof_pkg::F_TOD:   next_dat = {19'h0, trip_hour[ri], 2'h0, trip_minute[ri]};
                  default:          next_dat = 32'h0000_0000;
               endcase
            end
         end
      endcase
   end

   // read data held in a flop so it lines up with ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= next_dat;
      end
   end

   // ==========================================
   // discrete input synchroniser
   logic [15:0] disc_meta;
   logic [15:0] disc_sync;

   // floats are asynchronous to us; two flops before use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disc_meta <= 16'h0000;
         disc_sync <= 16'h0000;
      end else begin
         disc_meta <= disc_i;
         disc_sync <= disc_meta;
      end
   end

   // ==========================================
   // flow condition detector
   logic [1:0] flow_code;

   eof_flow_det u_flow (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .upd_i    (upd_i),
      .type_i   (flow_src_type),
      .point_i  (flow_src_point),
      .on_i     (flow_on_level),
      .off_i    (flow_off_level),
      .lvl_i    (level_i),
      .rate_i   (rate_i),
      .disc_i   (disc_sync),
      .status_o (flow_code)
   );

   // ==========================================
   // override triggers
   logic man_act;
   logic flow_act;
   logic ovr_act;
   logic peak_use;
   logic [3:0] man_ix;

   // manual level follows the input directly, never stored
   always_comb begin
      man_ix   = 4'(manual_override_input_select - 5'h01);
      man_act  = (manual_override_input_select != 5'h00) &&
                 (manual_override_input_select <= eof_pkg::PT_MAX_DI) &&
                 disc_sync[man_ix];
      flow_act = (flow_code != eof_pkg::FS_NORMAL);
      ovr_act  = (energy_saving_mode == eof_pkg::ES_OVRD) && (man_act || flow_act);
      // mode 1 never yields; mode 0 ignores the peak
      peak_use = peak_i && (energy_saving_mode != eof_pkg::ES_OFF) && !ovr_act;
   end

   // ==========================================
   // relay evaluation on each update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         relay_o <= '0;
      end else if (upd_i) begin
         for (int r = 0; r < N; r++) begin
            if (is_pump(relay_control_function[r])) begin
               // pump down: start on high level, stop on low
               if (level_i[W-1:0] >= (peak_use ? peak_start_level[r] : on_level[r])) begin
                  relay_o[r] <= 1'b1;
               end else if (level_i[W-1:0] <=
                            (peak_use ? peak_stop_level[r] : off_level[r])) begin
                  relay_o[r] <= 1'b0;
               end
            end else if (relay_control_function[r] == eof_pkg::FN_TOD) begin
               // holds for the whole matching minute
               relay_o[r] <= (hour_i == trip_hour[r]) && (minute_i == trip_minute[r]);
            end else begin
               relay_o[r] <= 1'b0;
            end
         end
      end
   end

   // override codes shown only for pumps in the high-cost period; flow code always
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         override_status_o <= '0;
         flow_status_o     <= eof_pkg::FS_NORMAL;
      end else if (upd_i) begin
         for (int r = 0; r < N; r++) begin
            if (is_pump(relay_control_function[r]) && peak_i) begin
               override_status_o[2*r+:2] <= {man_act, flow_act};
            end else begin
               override_status_o[2*r+:2] <= eof_pkg::OS_NONE;
            end
         end
         flow_status_o <= flow_code;
      end
   end

   // ==========================================
   // checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_wb_ack_pulse: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a one-cycle answer");
   a_tod_trip: assert property (
      upd_i && relay_control_function[0] == 8'h09 && hour_i == trip_hour[0] &&
      minute_i == trip_minute[0] |=> relay_o[0])
      else $error("time of day relay failed to trip");
   a_nonpump_quiet: assert property (
      upd_i && (relay_control_function[0] < 8'h32 || relay_control_function[0] > 8'h38)
      |=> override_status_o[1:0] == 2'h0)
      else $error("override status on non-pump relay");
   a_both_code: assert property (
      upd_i && relay_control_function[0] == 8'h32 && peak_i && man_act &&
      flow_code != 2'h0 |=> override_status_o[1:0] == 2'h3)
      else $error("override status not 3 for both triggers");
   a_no_persist: assert property (
      upd_i && !peak_i |=> override_status_o == '0)
      else $error("override status outlived peak period");
   a_peak_stop: assert property (
      upd_i && relay_control_function[0] >= 8'h32 && relay_control_function[0] <= 8'h38 &&
      peak_i && energy_saving_mode != 2'h0 && !man_act && flow_code == 2'h0 &&
      level_i[W-1:0] <= peak_stop_level[0] && level_i[W-1:0] < peak_start_level[0]
      |=> !relay_o[0])
      else $error("pump kept running below peak stop level");
   a_peak_hold: assert property (
      upd_i && relay_control_function[0] >= 8'h32 && relay_control_function[0] <= 8'h38 &&
      peak_i && energy_saving_mode != 2'h0 && !man_act && flow_code == 2'h0 &&
      !relay_o[0] && level_i[W-1:0] < peak_start_level[0] |=> !relay_o[0])
      else $error("pump started below peak start level");
   a_man_sel_off: assert property (
      upd_i && manual_override_input_select == 5'h00 |=> !override_status_o[1])
      else $error("manual override with no input selected");
   a_ovr_normal: assert property (
      upd_i && relay_control_function[0] >= 8'h32 && relay_control_function[0] <= 8'h38 &&
      peak_i && energy_saving_mode == 2'h2 && man_act &&
      level_i[W-1:0] > off_level[0] && level_i[W-1:0] < on_level[0]
      |=> relay_o[0] == $past(relay_o[0]))
      else $error("override did not restore normal pump levels");
   a_flow_status: assert property (
      upd_i |=> flow_status_o == $past(flow_code) && flow_status_o != 2'h3)
      else $error("flow status code wrong");
endmodule

// ===== core/eof_pkg.sv
// ==========================================
// energy override / flow detect constants
package eof_pkg;
   // ==========================================
   // sizes
   localparam int NREL = 4;
   localparam int LW   = 16;
   // ==========================================
   // wishbone byte offsets
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_FSRC  = 8'h04;
   localparam logic [7:0] A_FON   = 8'h08;
   localparam logic [7:0] A_FOFF  = 8'h0c;
   localparam logic [7:0] A_STAT  = 8'h10;
   // relay r block at (r+1)*0x20, field word index
   localparam logic [2:0] REL_BASE = 3'h1;
   localparam logic [2:0] F_FUNC   = 3'h0;
   localparam logic [2:0] F_ON     = 3'h1;
   localparam logic [2:0] F_OFF    = 3'h2;
   localparam logic [2:0] F_PKON   = 3'h3;
   localparam logic [2:0] F_PKOFF  = 3'h4;
   localparam logic [2:0] F_TOD    = 3'h5;
   // ==========================================
   // relay function codes
   localparam logic [7:0] FN_TOD      = 8'h09;
   localparam logic [7:0] FN_PUMP_LO  = 8'h32;
   localparam logic [7:0] FN_PUMP_HI  = 8'h38;
   // ==========================================
   // energy saving mode
   localparam logic [1:0] ES_OFF   = 2'h0;
   localparam logic [1:0] ES_AVOID = 2'h1;
   localparam logic [1:0] ES_OVRD  = 2'h2;
   // ==========================================
   // flow source types and points
   localparam logic [2:0] ST_OFF    = 3'h0;
   localparam logic [2:0] ST_OV_LVL = 3'h1;
   localparam logic [2:0] ST_OV_DI  = 3'h2;
   localparam logic [2:0] ST_UN_LVL = 3'h3;
   localparam logic [2:0] ST_UN_DI  = 3'h4;
   localparam logic [2:0] ST_OV_ROC = 3'h5;
   localparam logic [2:0] ST_UN_ROC = 3'h6;
   localparam logic [4:0] PT_MAX_TX = 5'h03;
   localparam logic [4:0] PT_MAX_DI = 5'h10;
   // ==========================================
   // status codes
   localparam logic [1:0] FS_NORMAL = 2'h0;
   localparam logic [1:0] FS_OVER   = 2'h1;
   localparam logic [1:0] FS_UNDER  = 2'h2;
   localparam logic [1:0] OS_NONE   = 2'h0;
endpackage

// ===== core/eof_flow_det.sv
`timescale 1ns/1ns
// ==========================================
// flow condition detector
module eof_flow_det (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // evaluation strobe
   input  wire logic                      upd_i,
   // source selection and thresholds
   input  wire logic [2:0]                type_i,
   input  wire logic [4:0]                point_i,
   input  wire logic [eof_pkg::LW-1:0]    on_i,
   input  wire logic [eof_pkg::LW-1:0]    off_i,
   // measurements (rates are signed)
   input  wire logic [3*eof_pkg::LW-1:0]  lvl_i,
   input  wire logic [3*eof_pkg::LW-1:0]  rate_i,
   input  wire logic [15:0]               disc_i,
   // condition
   output logic [1:0]                     status_o
);
   typedef enum logic [1:0] {EOF_NORM, EOF_OVER, EOF_UNDER} eof_fst_t;
   eof_fst_t state;
   logic     ena;
   logic     trig;
   logic     clr;
   logic     over;
   logic [eof_pkg::LW-1:0] lv;
   logic [eof_pkg::LW-1:0] rt;
   logic     tx_ok;
   logic     di_ok;
   logic [3:0] di_ix;

   // point 1..3 picks transducer 1, 2 or the combined reading
   always_comb begin
      tx_ok = (point_i != 5'h00) && (point_i <= eof_pkg::PT_MAX_TX);
      di_ok = (point_i != 5'h00) && (point_i <= eof_pkg::PT_MAX_DI);
      di_ix = 4'(point_i - 5'h01);
      lv = lvl_i[eof_pkg::LW*(2'(di_ix))+:eof_pkg::LW];
      rt = rate_i[eof_pkg::LW*(2'(di_ix))+:eof_pkg::LW];
   end

   // per-type trigger, release and direction sanity
   always_comb begin
      ena  = 1'b0;
      trig = 1'b0;
      clr  = 1'b0;
      over = 1'b1;
      case (type_i)
         eof_pkg::ST_OV_LVL: begin
            ena  = tx_ok && (on_i > off_i);
            trig = lv >= on_i;
            clr  = lv < off_i;
         end
         eof_pkg::ST_UN_LVL: begin
            over = 1'b0;
            ena  = tx_ok && (off_i > on_i);
            trig = lv <= on_i;
            clr  = lv > off_i;
         end
         eof_pkg::ST_OV_ROC: begin
            ena  = tx_ok && ($signed(on_i) > $signed(off_i));
            trig = $signed(rt) >= $signed(on_i);
            clr  = $signed(rt) < $signed(off_i);
         end
         eof_pkg::ST_UN_ROC: begin
            over = 1'b0;
            ena  = tx_ok && ($signed(off_i) > $signed(on_i));
            trig = $signed(rt) <= $signed(on_i);
            clr  = $signed(rt) > $signed(off_i);
         end
         // thresholds play no part for a float
         eof_pkg::ST_OV_DI, eof_pkg::ST_UN_DI: begin
            over = (type_i == eof_pkg::ST_OV_DI);
            ena  = di_ok;
            trig = disc_i[di_ix];
            clr  = !disc_i[di_ix];
         end
         default: ena = 1'b0;
      endcase
   end

   // condition state, moved only on a measurement update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= EOF_NORM;
      end else if (upd_i) begin
         case (state)
            EOF_NORM: begin
               if (ena && trig) begin
                  state <= over ? EOF_OVER : EOF_UNDER;
               end
            end
            default: begin
               if (!ena || clr) begin
                  state <= EOF_NORM;
               end
            end
         endcase
      end
   end

   // view-only code
   always_comb begin
      case (state)
         EOF_OVER:  status_o = eof_pkg::FS_OVER;
         EOF_UNDER: status_o = eof_pkg::FS_UNDER;
         default:   status_o = eof_pkg::FS_NORMAL;
      endcase
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_src_disabled: assert property (
      upd_i && (type_i == 3'h0 || point_i == 5'h00) |=> status_o == 2'h0)
      else $error("flow condition with disabled source");
   a_over_dir: assert property (
      upd_i && type_i == 3'h1 && on_i <= off_i |=> status_o == 2'h0)
      else $error("overflow with on not above off");
   a_under_dir: assert property (
      upd_i && type_i == 3'h3 && off_i <= on_i |=> status_o == 2'h0)
      else $error("underflow with off not above on");
endmodule

// ===== bench/eof_plant.sv
`timescale 1ns/1ns
// ==========================================
// plant: transducers, floats, update tick
module eof_plant (
   // clock
   input  wire logic        clk_i,
   // readings wanted by the bench
   input  wire logic [47:0] want_i,
   input  wire logic [15:0] flt_i,
   // towards the controller
   output logic      [47:0] level_o,
   output logic      [47:0] rate_o,
   output logic      [15:0] disc_o,
   output logic             upd_o
);
   logic [1:0] tick;
   // quiet start, no unknowns reach the controller
   initial begin
      {tick, level_o, rate_o, disc_o, upd_o} = '0;
   end
   // new readings land only with a tick, so they never change mid-update
   always @(posedge clk_i) begin
      tick <= tick + 2'h1;
      upd_o <= (tick == 2'h3);
      if (tick == 2'h3) begin
         level_o <= want_i;
         rate_o <= want_i;
         disc_o <= flt_i;
      end
   end
endmodule

// ===== bench/eof_energy_ctl_bench.sv
`timescale 1ns/1ns
// ==========================================
// bench for energy override and flow detect
module eof_energy_ctl_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd;
   logic [31:0] dat_o;
   logic        ack;
   logic        upd;
   logic        peak = 1'b0;
   logic [4:0]  hour = 5'h00;
   logic [5:0]  minute = 6'h00;
   logic [47:0] want = 48'h0;
   logic [47:0] lvl;
   logic [47:0] rate;
   logic [15:0] flt = 16'h0;
   logic [15:0] disc;
   logic [3:0]  relay;
   logic [1:0]  fstat;
   logic [7:0]  ostat;
   int          fails = 0;
   int          total_checks = 0;
   // flow cases: type, point, on, off, expected code when tripped
   int          tt[9] = '{1, 3, 5, 6, 2, 4, 1, 1, 3};
   int          pp[9] = '{1, 2, 3, 1, 5, 12, 1, 0, 2};
   int          fon[9] = '{1000, 500, 200, -200, 0, 0, 500, 1000, 1000};
   int          fof[9] = '{500, 1000, 100, -100, 0, 0, 1000, 500, 500};
   int          cd[9] = '{1, 2, 1, 2, 1, 2, 0, 0, 0};
   int          a, m, e, v, w;
   logic        ov;
   logic [47:0] wv;
   logic [15:0] fv;
   // ==========================================
   // clock, dut and plant
   always #20 clk_i = ~clk_i;
   eof_energy_ctl u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .upd_i(upd), .level_i(lvl),
      .rate_i(rate), .hour_i(hour), .minute_i(minute), .peak_i(peak),
      .disc_i(disc), .relay_o(relay), .flow_status_o(fstat),
      .override_status_o(ostat));
   eof_plant u_plant (
      .clk_i(clk_i), .want_i(want), .flt_i(flt), .level_o(lvl),
      .rate_o(rate), .disc_o(disc), .upd_o(upd));
   // ==========================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      total_checks++;
      if (g !== ex) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, ex, g);
      end
   endtask
   // classic cycle, held until ack is sampled high
   task automatic wb(input logic w_, input logic [7:0] a_, input logic [31:0] d_);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_;
      adr <= a_;
      wdat <= d_;
      // no limit here: the watchdog ends a wait that never gets its ack
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // three updates flush the detector and output stages
   task automatic settle;
      repeat (3) @(posedge clk_i iff upd);
      @(posedge clk_i);
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #400000;
      fails++;
      complete_run();
   end
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'h599768b9));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, eof_pkg::A_CTRL, 32'h0);
      chk("ctrl", 32'h0, rd);
      wb(1'b1, 8'hfc, 32'hffff);
      wb(1'b0, 8'hfc, 32'h0);
      chk("hole", 32'h0, rd);
      wb(1'b1, 8'h20, 32'(eof_pkg::FN_PUMP_LO));
      wb(1'b1, 8'h40, 32'(eof_pkg::FN_TOD));
      wb(1'b1, 8'h54, 32'h071e);
      wb(1'b1, eof_pkg::A_CTRL, 32'h0302);
      peak <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         a = $urandom % 2;
         m = $urandom % 2;
         ov = (tt[k] == 1 || tt[k] == 2 || tt[k] == 5);
         w = ov ? fof[k] - 50 : fof[k] + 50;
         v = (a == 0) ? w : (ov ? fon[k] + 50 : fon[k] - 50);
         wv = {3{w[15:0]}};
         if (pp[k] >= 1 && pp[k] <= 3) wv[16*(pp[k]-1) +: 16] = v[15:0];
         if (pp[k] == 0) wv = {3{v[15:0]}}; // a point-0 source must still stay quiet
         fv = 16'($urandom);
         if (pp[k] > 0) fv[pp[k]-1] = a[0];
         fv[2] = m[0];
         want <= wv;
         flt <= fv;
         e = (a == 1) ? cd[k] : 0;
         wb(1'b1, eof_pkg::A_FSRC, 32'h0);
         settle();
         chk("off", 32'h0, 32'(fstat));
         wb(1'b1, eof_pkg::A_FON, 32'(fon[k] & 16'hffff));
         wb(1'b1, eof_pkg::A_FOFF, 32'(fof[k] & 16'hffff));
         wb(1'b1, eof_pkg::A_FSRC, 32'((pp[k] << 8) | tt[k]));
         settle();
         chk("flow", 32'(e), 32'(fstat));
         wb(1'b0, eof_pkg::A_STAT, 32'h0);
         chk("stat", 32'(e), 32'(rd[9:8]));
         chk("ovr0", 32'({m[0], e != 0}), 32'(ostat[1:0]));
         chk("ovr1", 32'h0, 32'(ostat[3:2]));
      end
      // pump 0 in the high-cost period, no trigger: peak levels rule
      wb(1'b1, 8'h24, 32'h0320);
      wb(1'b1, 8'h28, 32'h00c8);
      wb(1'b1, 8'h2c, 32'h0384);
      wb(1'b1, 8'h30, 32'h0190);
      flt[2] <= 1'b0;
      want <= {3{16'h012c}};
      settle();
      chk("pk_stop", 32'h0, 32'(relay[0]));
      want <= {3{16'h0352}};
      settle();
      chk("pk_wait", 32'h0, 32'(relay[0]));
      want <= {3{16'h03b6}};
      settle();
      chk("pk_start", 32'h1, 32'(relay[0]));
      // manual trigger first, then a level that only the peak stop would end
      flt[2] <= 1'b1;
      settle();
      want <= {3{16'h012c}};
      settle();
      chk("ovr_run", 32'h1, 32'(relay[0]));
      // manual trigger held, override must end with the high-cost period
      peak <= 1'b0;
      flt[2] <= 1'b1;
      settle();
      chk("ovr_end", 32'h0, 32'(ostat));
      hour <= 5'h07;
      minute <= 6'h1e;
      settle();
      chk("tod_hit", 32'h1, 32'(relay[1]));
      minute <= 6'h1f;
      settle();
      chk("tod_miss", 32'h0, 32'(relay[1]));
      complete_run();
   end
endmodule
